// ===== rtl/hsu_ones_det.sv
`timescale 1ns/1ns
module hsu_ones_det
  import hsu_pkg::*;
#(
  parameter int IDLE_RUN  = IDLE_ONES,
  parameter int ABORT_RUN = ABORT_ONES
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_bit_stb,
  input  wire logic i_bit_val,
  output logic      o_abort_pulse,
  output logic      o_idle_pulse,
  output logic      o_idle_level
);
  logic [4:0] run_reg;

  // saturating count of consecutive ones, cleared by a zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_reg <= 5'h00;
    end else if (i_bit_stb) begin
      if (!i_bit_val) begin
        run_reg <= 5'h00;
      end else if (run_reg != 5'(IDLE_RUN)) begin
        run_reg <= run_reg + 5'h01;
      end
    end
  end

  // one pulse when a run first reaches each length
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_abort_pulse <= 1'b0;
      o_idle_pulse  <= 1'b0;
    end else begin
      o_abort_pulse <= i_bit_stb && i_bit_val
                       && run_reg == 5'(ABORT_RUN - 1);
      o_idle_pulse  <= i_bit_stb && i_bit_val
                       && run_reg == 5'(IDLE_RUN - 1);
    end
  end

  assign o_idle_level = (run_reg == 5'(IDLE_RUN));
endmodule : hsu_ones_det

// ===== rtl/hsu_pkg.sv
package hsu_pkg;

  // register offsets on the plain register port
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS = 8'h08;

  // channel_control field positions
  localparam int CTL_RX_DMA_EN = 0;
  localparam int CTL_TX_DMA_EN = 1;
  localparam int CTL_RX_STSK   = 2;
  localparam int CTL_TX_STSK   = 3;
  localparam int CTL_PLL_EN    = 4;
  localparam int CTL_CODE_LSB  = 5;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_007F;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // line coding values in the control code field
  localparam logic [1:0] CODE_NRZ  = 2'h0;
  localparam logic [1:0] CODE_NRZI = 2'h1;
  localparam logic [1:0] CODE_FM   = 2'h2;
  localparam logic [1:0] CODE_MAN  = 2'h3;

  // channel_status bit positions
  localparam int ST_FV    = 14;
  localparam int ST_IDLE  = 15;
  localparam int ST_ABT   = 16;
  localparam int ST_CRC   = 17;
  localparam int ST_NO    = 18;
  localparam int ST_OV    = 19;
  localparam int ST_MOV   = 20;
  localparam int ST_TXABT = 22;
  localparam int ST_IERR  = 23;
  localparam int ST_RXFD  = 24;
  localparam int ST_RXNL  = 25;
  localparam int ST_RX_NOT_OCTET  = 26;
  localparam int ST_TXFD  = 27;
  localparam int ST_TXNL  = 28;
  localparam int ST_TXNO  = 29;
  localparam int ST_PLL1  = 30;
  localparam int ST_PLL2  = 31;
  localparam logic [31:0] STAT_IMPL  = 32'hFFDF_C000;
  localparam logic [31:0] STAT_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;

  // run lengths of consecutive ones on the line
  localparam int IDLE_ONES  = 15;
  localparam int ABORT_ONES = 7;

  // register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } hsu_bus_t;

  // event pulses from receiver, transmitter, dma engine and dpll
  typedef struct packed {
    logic rx_in_frame;
    logic rx_last_in_fifo;
    logic rx_frame_ok;
    logic rx_frame_end;
    logic rx_crc_bad;
    logic rx_not_octet;
    logic rx_push;
    logic rx_fifo_full;
    logic rx_no_buffer;
    logic tx_abort_sent;
    logic rx_clk_unstable;
    logic rx_dma_done;
    logic rx_null_ptr;
    logic rx_not_owned;
    logic tx_dma_done;
    logic tx_null_ptr;
    logic tx_not_owned;
    logic pll_miss;
    logic pll_edge_found;
  } hsu_evt_t;

endpackage : hsu_pkg

// ===== rtl/hsu_status.sv
`timescale 1ns/1ns
module hsu_status (
  input  wire logic      i_clk,
  input  wire logic      i_rst_n,
  input  wire logic      i_rx_clk_pin,
  input  wire logic      i_rx_data_pin,
  input  hsu_pkg::hsu_bus_t i_bus,
  input  hsu_pkg::hsu_evt_t i_evt,
  output logic [31:0]    o_rdata,
  output logic           o_irq,
  output logic           o_rx_dma_enable,
  output logic           o_tx_dma_enable,
  output logic           o_rx_fifo_flush,
  output logic           o_rx_fifo_overwrite,
  output logic           o_pll_search,
  output logic           o_line_idle
);
  import hsu_pkg::*;

  typedef enum logic {PLL_TRACK, PLL_MISSED_ONE} hsu_pll_t;

  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  logic [31:0] stat_reg;
  logic [31:0] stat_next;
  logic [31:0] mask_reg;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic [31:0] stat_view;
  logic        clk_lvl;
  logic        clk_prev_reg;
  logic        data_lvl;
  logic        bit_stb;
  logic        abort_pulse;
  logic        idle_pulse;
  logic        idle_level;
  logic        pll_fm;
  logic        rx_dis;
  logic        tx_dis;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        wr_mask;
  logic        rd_any;
  hsu_pll_t    pll_reg;
  hsu_pll_t    pll_next;
  logic        pll_one_set;
  logic        pll_two_set;

  // address match shared by the write strobe decodes and the read select
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  // register port decode
  assign wr_ctrl = i_bus.wr && hit(i_bus.addr, CTRL_OFS);
  assign wr_stat = i_bus.wr && hit(i_bus.addr, STAT_OFS);
  assign wr_mask = i_bus.wr && hit(i_bus.addr, MASK_OFS);
  assign rd_any  = i_bus.rd;

  // link clock and data pass the pin synchronisers
  hsu_sync u_sync_clk (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_pin   (i_rx_clk_pin),
    .o_level (clk_lvl)
  );

  hsu_sync u_sync_data (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_pin   (i_rx_data_pin),
    .o_level (data_lvl)
  );

  // rising edge of the sampled link clock marks one line bit
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clk_prev_reg <= 1'b0;
    end else begin
      clk_prev_reg <= clk_lvl;
    end
  end

  assign bit_stb = clk_lvl && !clk_prev_reg;

  // run-of-ones detection for idle and abort
  hsu_ones_det #(
    .IDLE_RUN  (IDLE_ONES),
    .ABORT_RUN (ABORT_ONES)
  ) u_ones (
    .i_clk         (i_clk),
    .i_rst_n       (i_rst_n),
    .i_bit_stb     (bit_stb),
    .i_bit_val     (data_lvl),
    .o_abort_pulse (abort_pulse),
    .o_idle_pulse  (idle_pulse),
    .o_idle_level  (idle_level)
  );

  assign o_line_idle = idle_level;

  // dpll flags only set with fm or manchester coding and pll on
  assign pll_fm = ctrl_reg[CTL_PLL_EN]
                  && (ctrl_reg[CTL_CODE_LSB +: 2] == CODE_FM
                      || ctrl_reg[CTL_CODE_LSB +: 2] == CODE_MAN);

  // miss tracker: first miss, then second successive miss
  always_comb begin
    pll_next    = pll_reg;
    pll_one_set = 1'b0;
    pll_two_set = 1'b0;
    unique case (pll_reg)
      PLL_TRACK: begin
        if (pll_fm && i_evt.pll_miss) begin
          pll_one_set = 1'b1;
          pll_next    = PLL_MISSED_ONE;
        end
      end
      PLL_MISSED_ONE: begin
        if (!pll_fm || i_evt.pll_edge_found) begin
          pll_next = PLL_TRACK;
        end else if (i_evt.pll_miss) begin
          pll_two_set = 1'b1;
          pll_next    = PLL_TRACK;
        end
      end
    endcase
  end

  // dpll miss state
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pll_reg <= PLL_TRACK;
    end else begin
      pll_reg <= pll_next;
    end
  end

  // event set vector for the status flags
  always_comb begin
    set_vec           = 32'h0000_0000;
    set_vec[ST_FV]    = i_evt.rx_last_in_fifo && i_evt.rx_frame_ok;
    set_vec[ST_IDLE]  = idle_pulse;
    set_vec[ST_ABT]   = abort_pulse && i_evt.rx_in_frame;
    set_vec[ST_CRC]   = i_evt.rx_frame_end && i_evt.rx_crc_bad;
    set_vec[ST_NO]    = i_evt.rx_frame_end && i_evt.rx_not_octet;
    set_vec[ST_OV]    = i_evt.rx_push && i_evt.rx_fifo_full;
    set_vec[ST_MOV]   = i_evt.rx_no_buffer;
    set_vec[ST_TXABT] = i_evt.tx_abort_sent;
    set_vec[ST_IERR]  = i_evt.rx_clk_unstable;
    set_vec[ST_RXFD]  = i_evt.rx_dma_done;
    set_vec[ST_RXNL]  = i_evt.rx_null_ptr;
    set_vec[ST_RX_NOT_OCTET]  = i_evt.rx_not_owned && ctrl_reg[CTL_RX_STSK];
    set_vec[ST_TXFD]  = i_evt.tx_dma_done;
    set_vec[ST_TXNL]  = i_evt.tx_null_ptr;
    set_vec[ST_TXNO]  = i_evt.tx_not_owned && ctrl_reg[CTL_TX_STSK];
    set_vec[ST_PLL1]  = pll_one_set;
    set_vec[ST_PLL2]  = pll_two_set;
  end

  // dma shutdown causes per direction
  assign rx_dis = set_vec[ST_MOV] || set_vec[ST_RXNL]
                  || set_vec[ST_RX_NOT_OCTET];
  assign tx_dis = set_vec[ST_TXABT] || set_vec[ST_TXNL]
                  || set_vec[ST_TXNO];

  // control update; hardware disable beats a software enable
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = i_bus.wdata & CTRL_WMASK;
    end
    if (rx_dis) begin
      ctrl_next[CTL_RX_DMA_EN] = 1'b0;
    end
    if (tx_dis) begin
      ctrl_next[CTL_TX_DMA_EN] = 1'b0;
    end
  end

  // channel_control storage
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_reg <= CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // write-one-to-clear; a new event in the same cycle wins
  assign clr_vec = wr_stat ? i_bus.wdata : 32'h0000_0000;

  always_comb begin
    stat_next = ((stat_reg & ~clr_vec) | set_vec) & STAT_IMPL;
    if (!pll_fm) begin
      stat_next[ST_PLL2] = 1'b0;
    end
  end

  // channel_status storage
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stat_reg <= STAT_RESET;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // interrupt enable storage
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mask_reg <= MASK_RESET;
    end else if (wr_mask) begin
      mask_reg <= i_bus.wdata & STAT_IMPL;
    end
  end

  // idle bit also follows the live idle line
  always_comb begin
    stat_view          = stat_reg;
    stat_view[ST_IDLE] = stat_reg[ST_IDLE] || idle_level;
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (!rd_any) begin
      o_rdata <= 32'h0000_0000;
    end else if (hit(i_bus.addr, CTRL_OFS)) begin
      o_rdata <= ctrl_reg;
    end else if (hit(i_bus.addr, STAT_OFS)) begin
      o_rdata <= stat_view;
    end else if (hit(i_bus.addr, MASK_OFS)) begin
      o_rdata <= mask_reg;
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  // pulses toward fifo and dpll
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rx_fifo_flush     <= 1'b0;
      o_rx_fifo_overwrite <= 1'b0;
      o_pll_search        <= 1'b0;
    end else begin
      o_rx_fifo_flush     <= set_vec[ST_RXNL];
      o_rx_fifo_overwrite <= set_vec[ST_OV];
      o_pll_search        <= pll_two_set;
    end
  end

  // enables and masked interrupt level
  assign o_rx_dma_enable = ctrl_reg[CTL_RX_DMA_EN];
  assign o_tx_dma_enable = ctrl_reg[CTL_TX_DMA_EN];
  assign o_irq           = |(stat_reg & mask_reg);

  // checks of flag behaviour
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  frame_valid_set_a: assert property (
    i_evt.rx_last_in_fifo && i_evt.rx_frame_ok |=> stat_reg[ST_FV])
    else $error("frame valid flag not set");

  idle_store_a: assert property (
    idle_pulse |=> stat_reg[ST_IDLE] && o_line_idle)
    else $error("idle flag not stored");

  overrun_flag_a: assert property (
    i_evt.rx_push && i_evt.rx_fifo_full
    |=> stat_reg[ST_OV] && o_rx_fifo_overwrite)
    else $error("overrun not flagged");

  rx_mov_dis_a: assert property (
    i_evt.rx_no_buffer |=> stat_reg[ST_MOV] && !o_rx_dma_enable)
    else $error("memory overflow kept rx dma on");

  tx_abort_dis_a: assert property (
    i_evt.tx_abort_sent |=> stat_reg[ST_TXABT] && !o_tx_dma_enable)
    else $error("tx abort kept tx dma on");

  rx_null_flush_a: assert property (
    i_evt.rx_null_ptr |=> o_rx_fifo_flush && !o_rx_dma_enable
    ##1 !o_rx_fifo_flush || $past(i_evt.rx_null_ptr))
    else $error("null list did not flush once");

  rx_skip_gate_a: assert property (
    !ctrl_reg[CTL_RX_STSK] && !stat_reg[ST_RX_NOT_OCTET] |=> !stat_reg[ST_RX_NOT_OCTET])
    else $error("not owner set without stop on skip");

  tx_skip_gate_a: assert property (
    !ctrl_reg[CTL_TX_STSK] && !stat_reg[ST_TXNO] |=> !stat_reg[ST_TXNO])
    else $error("tx not owner set without stop on skip");

  tx_null_dis_a: assert property (
    i_evt.tx_null_ptr |=> stat_reg[ST_TXNL] && !o_tx_dma_enable)
    else $error("tx null list kept tx dma on");

  abort_store_a: assert property (
    abort_pulse && i_evt.rx_in_frame |=> stat_reg[ST_ABT])
    else $error("in-frame abort not stored");

  pll_search_a: assert property (
    pll_two_set |=> o_pll_search && stat_reg[ST_PLL2])
    else $error("second miss gave no search or flag");

  pll_two_zero_a: assert property (
    !pll_fm |=> !stat_reg[ST_PLL2])
    else $error("two missed flag outside fm coding");

  irq_mask_a: assert property (
    mask_reg == 32'h0000_0000 |-> !o_irq)
    else $error("interrupt with all enables off");

  write_zero_a: assert property (
    wr_stat && !i_bus.wdata[ST_FV] && stat_reg[ST_FV] |=> stat_reg[ST_FV])
    else $error("writing zero cleared a flag");

  reserved_zero_a: assert property (
    $past(rd_any) |-> !o_rdata[21])
    else $error("reserved bit read as one");

  cov_frame_irq: cover property (
    stat_reg[ST_FV] && mask_reg[ST_FV] && o_irq);
  cov_overrun: cover property (o_rx_fifo_overwrite);
  cov_pll_search: cover property (o_pll_search ##1 stat_reg[ST_PLL2]);
  cov_abort: cover property (abort_pulse && i_evt.rx_in_frame);
endmodule : hsu_status

// ===== rtl/hsu_sync.sv
`timescale 1ns/1ns
module hsu_sync (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_pin,
  output logic      o_level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // three-stage chain; first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= i_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // level moves only once stages two and three agree
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_level <= 1'b0;
    end else if (s2_reg == s3_reg) begin
      o_level <= s3_reg;
    end
  end
endmodule : hsu_sync

// ===== testbench/hsu_peer.sv
`timescale 1ns/1ns
// remote station: clocks bits onto the serial line, clock still between frames
module hsu_peer (
  output logic o_lclk,
  output logic o_ldata
);
  initial begin
    o_lclk  = 1'h0;
    o_ldata = 1'h0;
  end

  // lsb first; data moves on the falling edge, sampled on the rise
  task automatic send(input logic [31:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      o_ldata = bits[i];
      #63 o_lclk = 1'h1;
      #62 o_lclk = 1'h0;
    end
    o_ldata = ~o_ldata; // line released: no longer shows the last bit
  endtask : send
endmodule : hsu_peer

// ===== testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
  import hsu_pkg::*;
  logic        i_clk, i_rst_n, o_irq, lclk, ldata, fl, ow, ps;
  logic        o_rx_dma_enable, o_tx_dma_enable, o_rx_fifo_flush;
  logic        o_rx_fifo_overwrite, o_pll_search, o_line_idle, in_frm;
  logic [31:0] o_rdata, d, ce;
  hsu_bus_t    bus;
  hsu_evt_t    ev, e;
  int          n_fail, checked, cyc, b;
  int          tab[13] = '{14, 17, 18, 19, 20, 22, 23, 24, 25, 26, 27, 28, 29};

  hsu_status dut_u (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_rx_clk_pin(lclk),
    .i_rx_data_pin(ldata), .i_bus(bus), .i_evt(ev), .o_rdata(o_rdata),
    .o_irq(o_irq), .o_rx_dma_enable(o_rx_dma_enable),
    .o_tx_dma_enable(o_tx_dma_enable), .o_rx_fifo_flush(o_rx_fifo_flush),
    .o_rx_fifo_overwrite(o_rx_fifo_overwrite), .o_pll_search(o_pll_search),
    .o_line_idle(o_line_idle)
  );
  hsu_peer peer_u (.o_lclk(lclk), .o_ldata(ldata));

  // clock, reset and time-zero input values
  initial begin
    i_clk = 1'h0;
    forever #2 i_clk = ~i_clk;
  end
  initial begin
    i_rst_n = 1'h0;
    bus = '0;
    ev = '0;
    in_frm = 1'h0;
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'h1;
  end

  task automatic wrap_up();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge i_clk);
    bus.wr <= 1'h1;
    bus.addr <= a;
    bus.wdata <= w;
    @(posedge i_clk);
    bus.wr <= 1'h0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    bus.rd <= 1'h1;
    bus.addr <= a;
    @(posedge i_clk);
    bus.rd <= 1'h0;
    #1 d = o_rdata;
    chk(d, exp);
  endtask : rdc

  // one-cycle event, pulses captured in the cycle after it is taken
  task automatic pulse(input hsu_evt_t p);
    hsu_evt_t z;
    z = '0;
    z.rx_in_frame = in_frm;
    @(posedge i_clk);
    ev <= p;
    @(posedge i_clk);
    ev <= z;
    #1 fl = o_rx_fifo_flush;
    ow = o_rx_fifo_overwrite;
    ps = o_pll_search;
  endtask : pulse

  function automatic hsu_evt_t mk(input int k);
    hsu_evt_t m;
    m = '0;
    case (k)
      14: begin m.rx_frame_ok = 1'h1; m.rx_last_in_fifo = 1'h1; end
      17: begin m.rx_frame_end = 1'h1; m.rx_crc_bad = 1'h1; end
      18: begin m.rx_frame_end = 1'h1; m.rx_not_octet = 1'h1; end
      19: begin m.rx_push = 1'h1; m.rx_fifo_full = 1'h1; end
      20: m.rx_no_buffer = 1'h1;
      22: m.tx_abort_sent = 1'h1;
      23: m.rx_clk_unstable = 1'h1;
      24: m.rx_dma_done = 1'h1;
      25: m.rx_null_ptr = 1'h1;
      26: m.rx_not_owned = 1'h1;
      27: m.tx_dma_done = 1'h1;
      28: m.tx_null_ptr = 1'h1;
      default: m.tx_not_owned = 1'h1;
    endcase
    return m;
  endfunction : mk

  // main sequence
  initial begin
    @(posedge i_rst_n);
    rdc(CTRL_OFS, 32'h0000_0000);
    rdc(STAT_OFS, 32'h0000_0000);
    rdc(MASK_OFS, 32'h0000_0000);
    wr(8'hFC, 32'hFFFF_FFFF);
    rdc(8'hFC, 32'h0000_0000);
    wr(CTRL_OFS, 32'hFFFF_FFFF);
    rdc(CTRL_OFS, 32'h0000_007F);
    // each event alone: flag, dma enables, pulses, mask, clear
    for (int k = 0; k < 13; k++) begin
      b = tab[k];
      ce = 32'h0000_000F;
      if (b == 20 || b == 25 || b == 26) ce[0] = 1'h0;
      if (b == 22 || b == 28 || b == 29) ce[1] = 1'h0;
      wr(CTRL_OFS, 32'h0000_000F);
      wr(MASK_OFS, ~(32'h1 << b));
      pulse(mk(b));
      chk({30'h0, fl, ow}, {30'h0, b == 25, b == 19});
      chk({30'h0, o_tx_dma_enable, o_rx_dma_enable},
          ce & 32'h0000_0003);
      rdc(STAT_OFS, 32'h1 << b);
      chk({31'h0, o_irq}, 32'h0);
      wr(MASK_OFS, 32'h1 << b);
      rdc(CTRL_OFS, ce);
      chk({31'h0, o_irq}, 32'h1);
      wr(STAT_OFS, 32'h0000_0000);
      rdc(STAT_OFS, 32'h1 << b);
      wr(STAT_OFS, 32'h1 << b);
      rdc(STAT_OFS, 32'h0000_0000);
      chk({31'h0, o_irq}, 32'h0);
    end
    // not-owner refused without stop-on-skip
    wr(CTRL_OFS, 32'h0000_0003);
    e = '0;
    e.rx_not_owned = 1'h1;
    e.tx_not_owned = 1'h1;
    pulse(e);
    rdc(STAT_OFS, 32'h0000_0000);
    rdc(CTRL_OFS, 32'h0000_0003);
    // everything at once in manchester with the dpll on
    wr(CTRL_OFS, 32'h0000_007F);
    e = '1;
    e.pll_edge_found = 1'h0;
    e.rx_in_frame = 1'h0;
    pulse(e);
    chk({31'h0, ps}, 32'h0);
    rdc(STAT_OFS, 32'h7FDE_4000);
    e = '0;
    e.pll_miss = 1'h1;
    pulse(e);
    chk({31'h0, ps}, 32'h1);
    rdc(STAT_OFS, 32'hFFDE_4000);
    wr(STAT_OFS, 32'hFFFF_FFFF);
    pulse(e);
    pulse(mk(0) ^ mk(0) | 19'h1); // lsb is pll_edge_found
    pulse(e);
    chk({31'h0, ps}, 32'h0);
    rdc(STAT_OFS, 32'h4000_0000);
    // nrz with dpll on, fm with dpll off, nrzi with dpll on
    for (int k = 0; k < 3; k++) begin
      wr(CTRL_OFS, k == 2 ? 32'h0000_0030
                   : k ? 32'h0000_0040 : 32'h0000_0010);
      wr(STAT_OFS, 32'hFFFF_FFFF);
      pulse(e);
      pulse(e);
      chk({31'h0, ps}, 32'h0);
      rdc(STAT_OFS, 32'h0000_0000);
    end
    // fm with dpll on: two misses give both flags and search
    wr(CTRL_OFS, 32'h0000_0050);
    wr(STAT_OFS, 32'hFFFF_FFFF);
    pulse(e);
    pulse(e);
    chk({31'h0, ps}, 32'h1);
    rdc(STAT_OFS, 32'hC000_0000);
    wr(STAT_OFS, 32'hFFFF_FFFF);
    // abort in frame: six ones do nothing, the seventh stores it
    in_frm = 1'h1;
    ev <= '0 | 19'h4_0000;
    wr(MASK_OFS, 32'h0001_0000);
    peer_u.send(32'h0000_007E, 7);
    repeat (10) @(posedge i_clk);
    rdc(STAT_OFS, 32'h0000_0000);
    peer_u.send(32'h0000_0001, 1);
    repeat (10) @(posedge i_clk);
    rdc(STAT_OFS, 32'h0001_0000);
    chk({31'h0, o_irq}, 32'h1);
    wr(STAT_OFS, 32'h0001_0000);
    // out of frame: 14 ones no idle, no abort; 15th gives idle
    in_frm = 1'h0;
    ev <= '0;
    peer_u.send(32'h0000_7FFE, 15);
    repeat (10) @(posedge i_clk);
    chk({31'h0, o_line_idle}, 32'h0);
    rdc(STAT_OFS, 32'h0000_0000);
    peer_u.send(32'h0000_0001, 1);
    repeat (10) @(posedge i_clk);
    chk({31'h0, o_line_idle}, 32'h1);
    rdc(STAT_OFS, 32'h0000_8000);
    peer_u.send(32'h0000_0000, 1);
    repeat (10) @(posedge i_clk);
    chk({31'h0, o_line_idle}, 32'h0);
    rdc(STAT_OFS, 32'h0000_8000);
    wr(STAT_OFS, 32'h0000_8000);
    rdc(STAT_OFS, 32'h0000_0000);
    wrap_up();
  end
endmodule : testbench
